// ===== logic/bpx_cfg.svh
// constants for the backplane address/data transceiver slice
// assumes the includer is the package or a module on the single mclk domain
`ifndef BPX_CFG_SVH
`define BPX_CFG_SVH

`define BPX_BUS_W      16
`define BPX_ID_W       4
`define BPX_HI_MSB     15
`define BPX_HI_LSB     12
`define BPX_MID_MSB    11
`define BPX_MID_LSB    8
`define BPX_SYNC_STAGES 2
`define BPX_REG_RST    16'h0000
`define BPX_ID_RST     4'hF
`define BPX_CTRL_RST   8'h37

`endif

// ===== logic/bpx_pkg.sv
// types used by the transceiver slice to carry its pins through one synchroniser
// assumes bpx_cfg.svh sits on the include path
`include "bpx_cfg.svh"

package bpx_pkg;

  // control pins, all sampled from outside the mclk domain
  typedef struct packed {
    logic addr_clk;
    logic data_clk;
    logic addr_le_n;
    logic data_le_n;
    logic sel;
    logic bp_oe_n;
    logic addr_oe_n;
    logic data_oe_n;
  } bpx_ctrl_t;

  // every pin level that crosses into mclk travels together
  typedef struct packed {
    bpx_ctrl_t                 ctrl;
    logic [`BPX_BUS_W-1:0]     bp;
    logic [`BPX_BUS_W-1:0]     la;
    logic [`BPX_BUS_W-1:0]     ld;
    logic [`BPX_ID_W-1:0]      id;
    logic [`BPX_ID_W-1:0]      id_drv;
  } bpx_pins_t;

endpackage : bpx_pkg

// ===== logic/bpx_sync.sv
// two-stage level synchroniser for a vector of pin inputs
// assumes inputs are asynchronous to mclk; bus skew is settled by the caller
`timescale 1ns/1ns

module bpx_sync #(
  parameter int         W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         srst,
  // raw and settled levels
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second, nothing else looks at it
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : bpx_sync

// ===== logic/bpx_transceiver.sv
// one 16-bit slice of the backplane/local address-data transceiver
// assumes every pin input is asynchronous to mclk and that the testbench
// resolves each shared wire from the _drv/_oe pairs; pulses on the capture
// clocks and latch enables must last at least three mclk periods
`timescale 1ns/1ns
`include "bpx_cfg.svh"

module bpx_transceiver (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   srst,
  // control pins
  input  wire logic                   addr_capture_clk,
  input  wire logic                   data_capture_clk,
  input  wire logic                   local_addr_latch_en_n,
  input  wire logic                   local_data_latch_en_n,
  input  wire logic                   addr_data_sel,
  input  wire logic                   backplane_out_en_n,
  input  wire logic                   local_addr_out_en_n,
  input  wire logic                   local_data_out_en_n,
  // slot identification straps
  input  wire logic [`BPX_ID_W-1:0]   slot_id,
  input  wire logic [`BPX_ID_W-1:0]   slot_id_driven,
  // backplane address/data port
  input  wire logic [`BPX_BUS_W-1:0]  backplane_ad_port_pin,
  output      logic [`BPX_BUS_W-1:0]  backplane_ad_port_drv,
  output      logic                   backplane_ad_port_oe,
  // local address port
  input  wire logic [`BPX_BUS_W-1:0]  local_addr_port_pin,
  output      logic [`BPX_BUS_W-1:0]  local_addr_port_drv,
  output      logic                   local_addr_port_oe,
  // local data port
  input  wire logic [`BPX_BUS_W-1:0]  local_data_port_pin,
  output      logic [`BPX_BUS_W-1:0]  local_data_port_drv,
  output      logic                   local_data_port_oe,
  // comparator results
  output      logic                   slot_match_n,
  output      logic                   superslot_match_n
);

  localparam int W = $bits(bpx_pkg::bpx_pins_t);
  localparam logic [W-1:0] PIN_RST = {`BPX_CTRL_RST,
                                      {3{`BPX_REG_RST}},
                                      `BPX_ID_RST,
                                      {`BPX_ID_W{1'b1}}};

  // match against the stored backplane levels
  function automatic logic slot_hit(input logic [`BPX_BUS_W-1:0] a,
                                    input logic [`BPX_ID_W-1:0]  id);
    slot_hit = (a[`BPX_HI_MSB:`BPX_HI_LSB] == '0) &&
               (a[`BPX_MID_MSB:`BPX_MID_LSB] == id);
  endfunction : slot_hit

  function automatic logic superslot_hit(input logic [`BPX_BUS_W-1:0] a,
                                         input logic [`BPX_ID_W-1:0]  id);
    superslot_hit = (a[`BPX_HI_MSB:`BPX_HI_LSB] == id) && (id != '0);
  endfunction : superslot_hit

  bpx_pkg::bpx_pins_t raw;
  bpx_pkg::bpx_pins_t pin_s;
  bpx_pkg::bpx_ctrl_t ctl;

  logic                  aclk_prev_q;
  logic                  data_capture_clk_prev_q;
  logic [`BPX_BUS_W-1:0] areg_q;
  logic [`BPX_BUS_W-1:0] areg_d;
  logic [`BPX_BUS_W-1:0] dreg_q;
  logic [`BPX_BUS_W-1:0] dreg_d;
  logic [`BPX_BUS_W-1:0] alat_q;
  logic [`BPX_BUS_W-1:0] alat_d;
  logic [`BPX_BUS_W-1:0] dlat_q;
  logic [`BPX_BUS_W-1:0] dlat_d;
  logic [`BPX_ID_W-1:0]  id_eff;
  logic                  aclk_rise;
  logic                  data_capture_clk_rise;
  logic [`BPX_BUS_W-1:0] bp_next;

  // gather pins into one carrier so a single synchroniser serves them all
  assign raw.ctrl.addr_clk  = addr_capture_clk;
  assign raw.ctrl.data_clk  = data_capture_clk;
  assign raw.ctrl.addr_le_n = local_addr_latch_en_n;
  assign raw.ctrl.data_le_n = local_data_latch_en_n;
  assign raw.ctrl.sel       = addr_data_sel;
  assign raw.ctrl.bp_oe_n   = backplane_out_en_n;
  assign raw.ctrl.addr_oe_n = local_addr_out_en_n;
  assign raw.ctrl.data_oe_n = local_data_out_en_n;
  assign raw.bp             = backplane_ad_port_pin;
  assign raw.la             = local_addr_port_pin;
  assign raw.ld             = local_data_port_pin;
  assign raw.id             = slot_id;
  assign raw.id_drv         = slot_id_driven;

  bpx_sync #(
    .W       (W),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .mclk (mclk),
    .srst (srst),
    .d    (raw),
    .q    (pin_s)
  );

  assign ctl = pin_s.ctrl;

  // an undriven strap bit reads high, as the internal pull-up would give
  assign id_eff = pin_s.id | ~pin_s.id_drv;

  // capture clocks are sampled levels; their rise is found on settled copies
  assign aclk_rise = ctl.addr_clk & ~aclk_prev_q;
  assign data_capture_clk_rise = ctl.data_clk & ~data_capture_clk_prev_q;

  // registers keep the raw backplane levels so the comparator sees them as is
  assign areg_d = aclk_rise ? pin_s.bp : areg_q;
  assign dreg_d = data_capture_clk_rise ? pin_s.bp : dreg_q;

  // latches follow their port while enable is low, freeze once it rises;
  // the word kept is the last one sampled while open, so the local side
  // must hold its value steady across the closing edge
  assign alat_d = ctl.addr_le_n ? alat_q : pin_s.la;
  assign dlat_d = ctl.data_le_n ? dlat_q : pin_s.ld;

  // multiplexer toward the backplane, inverted on the way out
  // select and both latch words share one synchroniser, so a switch never mixes ports
  assign bp_next = ctl.sel ? ~dlat_d : ~alat_d;

  // edge detect history; cleared to the strobes' idle low level so that
  // leaving reset never looks like a capture edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      aclk_prev_q <= 1'b0;
      data_capture_clk_prev_q <= 1'b0;
    end else begin
      aclk_prev_q <= ctl.addr_clk;
      data_capture_clk_prev_q <= ctl.data_clk;
    end
  end

  // storage: capture registers and local latches
  always_ff @(posedge mclk) begin
    if (srst) begin
      areg_q <= `BPX_REG_RST;
      dreg_q <= `BPX_REG_RST;
      alat_q <= `BPX_REG_RST;
      dlat_q <= `BPX_REG_RST;
    end else begin
      areg_q <= areg_d;
      dreg_q <= dreg_d;
      alat_q <= alat_d;
      dlat_q <= dlat_d;
    end
  end

  // backplane driver; the oe only says who owns the wire, levels are the inverted latch word
  always_ff @(posedge mclk) begin
    if (srst) begin
      backplane_ad_port_drv <= `BPX_REG_RST;
      backplane_ad_port_oe  <= 1'b0;
    end else begin
      backplane_ad_port_drv <= bp_next;
      backplane_ad_port_oe  <= ~ctl.bp_oe_n;
    end
  end

  // local drivers use the newest register value so a capture and an
  // enable in the same cycle still present fresh data
  always_ff @(posedge mclk) begin
    if (srst) begin
      local_addr_port_drv <= `BPX_REG_RST;
      local_addr_port_oe  <= 1'b0;
      local_data_port_drv <= `BPX_REG_RST;
      local_data_port_oe  <= 1'b0;
    end else begin
      local_addr_port_drv <= ~areg_d;
      local_addr_port_oe  <= ~ctl.addr_oe_n;
      local_data_port_drv <= ~dreg_d;
      local_data_port_oe  <= ~ctl.data_oe_n;
    end
  end

  // comparator: recomputed every cycle from the register and live straps,
  // so a strap change shows without any capture edge; the cost is the
  // synchroniser plus one flop of latency on a strap change
  always_ff @(posedge mclk) begin
    if (srst) begin
      slot_match_n      <= 1'b1;
      superslot_match_n <= 1'b1;
    end else begin
      slot_match_n      <= ~slot_hit(areg_d, id_eff);
      superslot_match_n <= ~superslot_hit(areg_d, id_eff);
    end
  end

  // checks on the logic above
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  a_areg_capture: assert property (
    aclk_rise |=> areg_q == $past(pin_s.bp)
  ) else $error("address register missed a capture");

  a_dreg_capture: assert property (
    data_capture_clk_rise |=> dreg_q == $past(pin_s.bp)
  ) else $error("data register missed a capture");

  a_areg_holds: assert property (
    !aclk_rise |=> $stable(areg_q)
  ) else $error("address register changed without a capture edge");

  a_addr_latch_hold: assert property (
    ctl.addr_le_n && $past(ctl.addr_le_n) |-> $stable(alat_q)
  ) else $error("address latch moved while closed");

  a_data_latch_open: assert property (
    !ctl.data_le_n |=> dlat_q == $past(pin_s.ld)
  ) else $error("data latch not transparent");

  a_bp_data_path: assert property (
    !ctl.bp_oe_n && ctl.sel && !ctl.data_le_n
      |=> backplane_ad_port_oe && backplane_ad_port_drv == ~$past(pin_s.ld)
  ) else $error("backplane did not carry inverted local data");

  a_bp_addr_path: assert property (
    !ctl.bp_oe_n && !ctl.sel && !ctl.addr_le_n
      |=> backplane_ad_port_oe && backplane_ad_port_drv == ~$past(pin_s.la)
  ) else $error("backplane did not carry inverted local address");

  a_bp_float: assert property (
    ctl.bp_oe_n |=> !backplane_ad_port_oe
  ) else $error("backplane driven while disabled");

  a_local_addr_drv: assert property (
    !ctl.addr_oe_n && aclk_rise
      |=> local_addr_port_oe && local_addr_port_drv == ~$past(pin_s.bp)
  ) else $error("local address port wrong after capture");

  a_local_data_drv: assert property (
    ctl.data_oe_n |=> !local_data_port_oe ##0 local_data_port_drv == ~dreg_q
  ) else $error("local data port wrong");

  a_slot_match: assert property (
    1'b1 |=> slot_match_n == !(areg_q[15:12] == 4'h0 &&
                               areg_q[11:8] == $past(id_eff))
  ) else $error("slot match disagrees with register");

  a_superslot_match: assert property (
    1'b1 |=> superslot_match_n == !(areg_q[15:12] == $past(id_eff) &&
                                    $past(id_eff) != 4'h0)
  ) else $error("superslot match disagrees with register");

  a_match_steady: assert property (
    !aclk_rise && $stable(id_eff) |=> $stable(superslot_match_n) && $stable(slot_match_n)
  ) else $error("match output moved without cause");

  // holds, floats, latch opening, port capture and drive-on cases that the scenarios only touch in passing
  a_dreg_holds: assert property (
    !data_capture_clk_rise |=> $stable(dreg_q)
  ) else $error("data register changed without a capture edge");

  a_addr_latch_open: assert property (
    !ctl.addr_le_n |=> alat_q == $past(pin_s.la)
  ) else $error("address latch not transparent");

  a_data_latch_hold: assert property (
    ctl.data_le_n |=> $stable(dlat_q)
  ) else $error("data latch moved while closed");

  a_local_addr_float: assert property (
    ctl.addr_oe_n |=> !local_addr_port_oe
  ) else $error("local address port driven while disabled");

  a_local_data_cap: assert property (
    !ctl.data_oe_n && data_capture_clk_rise
      |=> local_data_port_oe && local_data_port_drv == ~$past(pin_s.bp)
  ) else $error("local data port wrong after capture");

  a_bp_drive_on: assert property (
    !ctl.bp_oe_n |=> backplane_ad_port_oe
  ) else $error("backplane not driven while enabled");

  // an all-zero slot code must never claim a superslot, whatever was captured
  a_superslot_zero: assert property (
    id_eff == '0 |=> superslot_match_n
  ) else $error("superslot match with an all-zero slot code");

  a_slot_high_set: assert property (
    areg_d[`BPX_HI_MSB:`BPX_HI_LSB] != '0 |=> slot_match_n
  ) else $error("slot match with a nonzero high nibble");

  // a strobe held high for many clocks must give one capture, not one per clock
  a_acapture_once: assert property (
    aclk_rise |=> !aclk_rise
  ) else $error("address capture taken twice from one strobe");

  a_dcapture_once: assert property (
    data_capture_clk_rise |=> !data_capture_clk_rise
  ) else $error("data capture taken twice from one strobe");

  // the drivers' reset value is not the inverse of a cleared register, so the
  // first edge out of reset is left out of these two
  a_addr_drv_steady: assert property (
    !aclk_rise && !$past(srst) |=> $stable(local_addr_port_drv)
  ) else $error("local address drive moved without a capture");

  a_data_drv_steady: assert property (
    !data_capture_clk_rise && !$past(srst) |=> $stable(local_data_port_drv)
  ) else $error("local data drive moved without a capture");

endmodule : bpx_transceiver

// ===== testbench/backplane_addr_data_transceiver_tb.sv
// self-checking bench for the transceiver slice
// assumes the backplane model resolves the bus; local wires are resolved here
`timescale 1ns/1ns

module backplane_addr_data_transceiver_tb;
  logic        mclk;
  logic        srst;
  logic        addr_capture_clk;
  logic        data_capture_clk;
  logic        ale_n;
  logic        dle_n;
  logic        sel;
  logic        bp_en_n;
  logic        la_en_n;
  logic        ld_en_n;
  logic [3:0]  id_val;
  logic [3:0]  id_drv;
  logic [3:0]  slot_id;
  logic [15:0] bp_drv;
  logic        bp_oe;
  logic [15:0] bp_w;
  logic [15:0] la_tb;
  logic [15:0] la_drv;
  logic        la_oe;
  logic [15:0] la_w;
  logic [15:0] ld_tb;
  logic [15:0] ld_drv;
  logic        ld_oe;
  logic [15:0] ld_w;
  logic        slot_match_n;
  logic        superslot_match_n;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;

  // an open strap bit floats low here, so only the device's own pull-up lifts it
  assign slot_id = id_val & id_drv;
  assign la_w    = la_oe ? la_drv : la_tb;
  assign ld_w    = ld_oe ? ld_drv : ld_tb;

  bpx_transceiver dut (
    .mclk(mclk), .srst(srst),
    .addr_capture_clk(addr_capture_clk), .data_capture_clk(data_capture_clk),
    .local_addr_latch_en_n(ale_n), .local_data_latch_en_n(dle_n),
    .addr_data_sel(sel), .backplane_out_en_n(bp_en_n),
    .local_addr_out_en_n(la_en_n), .local_data_out_en_n(ld_en_n),
    .slot_id(slot_id), .slot_id_driven(id_drv),
    .backplane_ad_port_pin(bp_w), .backplane_ad_port_drv(bp_drv),
    .backplane_ad_port_oe(bp_oe),
    .local_addr_port_pin(la_w), .local_addr_port_drv(la_drv), .local_addr_port_oe(la_oe),
    .local_data_port_pin(ld_w), .local_data_port_drv(ld_drv), .local_data_port_oe(ld_oe),
    .slot_match_n(slot_match_n), .superslot_match_n(superslot_match_n)
  );

  bpx_bp_model model (
    .mclk(mclk), .dev_drv(bp_drv), .dev_oe(bp_oe), .wire_lvl(bp_w),
    .addr_clk(addr_capture_clk), .data_clk(data_capture_clk)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // five clocks cover the three-clock pin path with margin
  task automatic step;
    repeat (5) @(posedge mclk);
    #1;
  endtask : step

  task automatic t_capture;
    la_en_n = 1'b0;
    ld_en_n = 1'b0;
    model.phase(1'b0, 16'h0000);
    model.phase(1'b0, 16'hA5C3);
    model.phase(1'b1, 16'h00FF);
    chk1(la_oe, 1'b1);
    chk16(la_w, 16'h5A3C);
    chk1(ld_oe, 1'b1);
    chk16(ld_w, 16'hFF00);
    la_en_n = 1'b1;
    ld_en_n = 1'b1;
    step();
    chk1(la_oe, 1'b0);
    chk1(ld_oe, 1'b0);
  endtask : t_capture

  task automatic t_send;
    bp_en_n = 1'b0;
    la_tb = 16'h3C96;
    step();
    chk1(bp_oe, 1'b1);
    chk16(bp_drv, 16'hC369);
    ale_n = 1'b1;
    step();
    la_tb = 16'h0001;
    sel = 1'b1;
    ld_tb = 16'h8001;
    step();
    chk16(bp_drv, 16'h7FFE);
    dle_n = 1'b1;
    step();
    ld_tb = 16'h1111;
    step();
    chk16(bp_drv, 16'h7FFE);
    sel = 1'b0;
    step();
    chk16(bp_drv, 16'hC369);
    bp_en_n = 1'b1;
    step();
    chk1(bp_oe, 1'b0);
  endtask : t_send

  // the bus toggles once released, so held results prove use of the register
  task automatic t_match;
    logic [15:0] adrs [6] = '{16'h0500, 16'h5000, 16'h0000, 16'h0F00, 16'hF000, 16'h6600};
    logic [3:0]  ids  [6] = '{4'h5, 4'h5, 4'h0, 4'h0, 4'h0, 4'h5};
    logic [3:0]  drvs [6] = '{4'hF, 4'hF, 4'hF, 4'h0, 4'h0, 4'hF};
    logic [3:0]  eid;
    for (int i = 0; i < 6; i++) begin
      id_val = ids[i];
      id_drv = drvs[i];
      model.phase(1'b0, adrs[i]);
      eid = (ids[i] & drvs[i]) | ~drvs[i];
      chk1(slot_match_n, !(adrs[i][15:12] == 4'h0 && adrs[i][11:8] == eid));
      chk1(superslot_match_n, !(adrs[i][15:12] == eid && eid != 4'h0));
    end
    id_val = 4'h6;
    step();
    chk1(superslot_match_n, 1'b0);
    model.phase(1'b1, 16'h0000);
    chk1(superslot_match_n, 1'b0);
  endtask : t_match

  task automatic end_sim;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // hang guard: the whole run needs well under a thousand clocks
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    srst = 1'b1;
    ale_n = 1'b0;
    dle_n = 1'b0;
    sel = 1'b0;
    bp_en_n = 1'b1;
    la_en_n = 1'b1;
    ld_en_n = 1'b1;
    id_val = 4'h0;
    id_drv = 4'hF;
    la_tb = 16'h0000;
    ld_tb = 16'h0000;
    repeat (16) @(posedge mclk);
    #1;
    srst = 1'b0;
    t_capture();
    t_send();
    t_match();
    end_sim();
  end
endmodule : backplane_addr_data_transceiver_tb

// ===== testbench/bpx_bp_model.sv
// backplane side model: drives the multiplexed bus and the capture strobes
// assumes the device drive wins on the wire while its enable is high
`timescale 1ns/1ns

module bpx_bp_model (
  // clock
  input  wire logic        mclk,
  // device side of the backplane wire
  input  wire logic [15:0] dev_drv,
  input  wire logic        dev_oe,
  // resolved wire and strobes
  output      logic [15:0] wire_lvl,
  output      logic        addr_clk,
  output      logic        data_clk
);
  logic [15:0] val = 16'h0000;
  logic        drv_en = 1'b0;
  logic [15:0] last_q;

  // a released bus shows the inverse of its last level, so stale values never pass
  assign wire_lvl = dev_oe ? dev_drv : (drv_en ? val : ~last_q);

  always_ff @(posedge mclk) begin
    last_q <= wire_lvl;
  end

  initial begin
    addr_clk = 1'b0;
    data_clk = 1'b0;
  end

  // one bus phase: value set up, strobe high, strobe low, bus released
  // each level lasts three clocks so the device's pin sampling sees it
  task automatic phase(input logic is_data, input logic [15:0] v);
    @(posedge mclk);
    #1;
    val = v;
    drv_en = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    addr_clk = !is_data;
    data_clk = is_data;
    repeat (3) @(posedge mclk);
    #1;
    addr_clk = 1'b0;
    data_clk = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    drv_en = 1'b0;
  endtask : phase
endmodule : bpx_bp_model
